// ===== verilog/wam_pkg.sv
package wam_pkg;

  // ----------------------------------------
  // register pointer values
  // ----------------------------------------
  localparam logic [2:0] PTR_RESULT = 3'h0;
  localparam logic [2:0] PTR_STATUS = 3'h1;
  localparam logic [2:0] PTR_CONFIG = 3'h2;
  localparam logic [2:0] PTR_LOW = 3'h3;
  localparam logic [2:0] PTR_HIGH = 3'h4;
  localparam logic [2:0] PTR_HYST = 3'h5;
  localparam logic [2:0] PTR_MIN = 3'h6;
  localparam logic [2:0] PTR_MAX = 3'h7;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_CYC_HI = 7;
  localparam int CFG_CYC_LO = 5;
  localparam int CFG_HOLD = 4;
  localparam int CFG_FLAG_EN = 3;
  localparam int CFG_PIN_EN = 2;
  localparam int CFG_POL = 0;
  localparam int STS_OVER = 1;
  localparam int STS_UNDER = 0;

  // ----------------------------------------
  // bus codes and addresses
  // ----------------------------------------
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam logic [2:0] ADDR_PREFIX = 3'h5;
  localparam logic [6:0] FIXED_ADDR = 7'h54;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_LAST = 4'h7;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK, BUS_RD, BUS_RD_ACK
  } bus_st_t;

  // ----------------------------------------
  // state of each clock domain
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] rst_s;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tog_s;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    bus_st_t st;
    logic [3:0] bits;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rw;
    logic mack;
    logic [1:0] byte_n;
    logic rd_lo;
    logic [7:0] wr_hi;
    logic [2:0] ptr;
    logic hs;
    logic sda_oe;
    logic [7:0] cfg;
    logic [11:0] low;
    logic [11:0] high;
    logic [11:0] hyst;
    logic [11:0] minv;
    logic [11:0] maxv;
    logic [11:0] res;
    logic over;
    logic under;
    logic alert;
  } link_st_t;

  typedef struct packed {
    logic [2:0] cyc_s1;
    logic [2:0] cyc_s2;
    logic [19:0] cnt;
    logic start;
    logic osc;
    logic tog;
    logic [11:0] hold;
  } ref_st_t;

  localparam link_st_t LINK_RST = '{st: BUS_IDLE, alert: 1'b1, high: 12'hFFF,
                                    minv: 12'hFFF, default: '0};
  localparam ref_st_t REF_RST = '{default: '0};

endpackage

// ===== verilog/i2c_window_alert_monitor.sv
`timescale 1ns/1ps
module i2c_window_alert_monitor #(
  parameter bit HAS_ADDR_PINS = 1'b1,
  parameter int AUTO_BASE_CYCLES = 16
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_select_high_pin_in, // 00 float, 01 gnd, 10 supply
  input wire logic [1:0] addr_select_low_pin_in,
  output logic conv_start_out,
  input wire logic conv_done_in,
  input wire logic [11:0] conv_result_in,
  output logic osc_en_out,
  output logic alert_out,
  output logic hs_mode_out
);

  localparam logic [19:0] BASE20 = 20'(AUTO_BASE_CYCLES);

  wam_pkg::link_st_t lk_q;
  wam_pkg::link_st_t lk_d;
  wam_pkg::ref_st_t rf_q;
  wam_pkg::ref_st_t rf_d;

  logic lrst_n;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic evt;
  logic two;
  logic auto_on;
  logic [11:0] smp;
  logic [6:0] my_addr;
  logic [15:0] word;
  logic [7:0] nb;
  logic [19:0] period;

  // ----------------------------------------
  // converter side, reference clock
  // ----------------------------------------

  // interval doubles with each cycle time step
  assign period = BASE20 << (rf_q.cyc_s2 - 3'h1);

  // auto conversion timer and result capture
  always_comb begin
    rf_d = rf_q;
    // cycle time is quasi static; a mixed code lasts one cycle at most
    rf_d.cyc_s1 = lk_q.cfg[wam_pkg::CFG_CYC_HI:wam_pkg::CFG_CYC_LO];
    rf_d.cyc_s2 = rf_q.cyc_s1;
    rf_d.start = 1'b0;
    rf_d.osc = (rf_q.cyc_s2 != 3'h0);
    if (rf_q.cyc_s2 != 3'h0) begin
      if (rf_q.cnt >= period - 20'h00001) begin
        rf_d.cnt = 20'h00000;
        rf_d.start = 1'b1;
      end else begin
        rf_d.cnt = rf_q.cnt + 20'h00001;
      end
    end else begin
      rf_d.cnt = 20'h00000;
    end
    // result held stable, toggle announces it
    if (conv_done_in) begin
      rf_d.hold = conv_result_in;
      rf_d.tog = ~rf_q.tog;
    end
    if (!rstn_in) begin
      rf_d = wam_pkg::REF_RST;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    rf_q <= rf_d;
  end

  assign conv_start_out = rf_q.start;
  assign osc_en_out = rf_q.osc;

  // ----------------------------------------
  // bus side, link clock
  // ----------------------------------------

  // synchronised pin events
  assign lrst_n = lk_q.rst_s[1];
  assign rise = lk_q.scl_s[1] & ~lk_q.scl_s[2];
  assign fall = ~lk_q.scl_s[1] & lk_q.scl_s[2];
  assign start_c = lk_q.scl_s[1] & lk_q.scl_s[2] & lk_q.sda_s[2] & ~lk_q.sda_s[1];
  assign stop_c = lk_q.scl_s[1] & lk_q.scl_s[2] & ~lk_q.sda_s[2] & lk_q.sda_s[1];
  assign evt = lk_q.tog_s[1] ^ lk_q.tog_s[2];
  assign smp = rf_q.hold;
  assign auto_on = (lk_q.cfg[wam_pkg::CFG_CYC_HI:wam_pkg::CFG_CYC_LO] != 3'h0);

  // own address from select pins or fixed
  assign my_addr = HAS_ADDR_PINS ? {wam_pkg::ADDR_PREFIX, lk_q.pin_s2}
                                 : wam_pkg::FIXED_ADDR;

  assign two = (lk_q.ptr != wam_pkg::PTR_STATUS) && (lk_q.ptr != wam_pkg::PTR_CONFIG);

  // register selected by the pointer
  always_comb begin
    word = 16'h0000;
    unique case (lk_q.ptr)
      wam_pkg::PTR_RESULT: word = {lk_q.cfg[wam_pkg::CFG_FLAG_EN] & (lk_q.over | lk_q.under),
                                   3'h0, lk_q.res};
      wam_pkg::PTR_STATUS: word = {14'h0000, lk_q.over, lk_q.under};
      wam_pkg::PTR_CONFIG: word = {8'h00, lk_q.cfg};
      wam_pkg::PTR_LOW: word = {4'h0, lk_q.low};
      wam_pkg::PTR_HIGH: word = {4'h0, lk_q.high};
      wam_pkg::PTR_HYST: word = {4'h0, lk_q.hyst};
      wam_pkg::PTR_MIN: word = {4'h0, lk_q.minv};
      wam_pkg::PTR_MAX: word = {4'h0, lk_q.maxv};
    endcase
  end

  // upper byte first on two-byte registers
  assign nb = (two && !lk_q.rd_lo) ? word[15:8] : word[7:0];

  // slave engine, monitor and alert pin
  always_comb begin
    logic load;
    logic [11:0] wv;
    load = 1'b0;
    wv = {lk_q.wr_hi[3:0], lk_q.shift};
    lk_d = lk_q;
    unique case (lk_q.st)
      wam_pkg::BUS_IDLE: begin
      end
      wam_pkg::BUS_ADDR: begin
        if (rise) begin
          lk_d.shift = {lk_q.shift[6:0], lk_q.sda_s[1]};
          lk_d.bits = lk_q.bits + 4'h1;
        end
        if (fall && lk_q.bits == wam_pkg::BITS_BYTE) begin
          if (lk_q.shift[7:1] == my_addr) begin
            lk_d.sda_oe = 1'b1;
            lk_d.rw = lk_q.shift[0];
            lk_d.st = wam_pkg::BUS_ADDR_ACK;
          end else begin
            lk_d.st = wam_pkg::BUS_IDLE;
            if (lk_q.shift[7:3] == wam_pkg::HS_CODE) begin
              lk_d.hs = 1'b1;
            end
          end
        end
      end
      wam_pkg::BUS_ADDR_ACK: begin
        if (fall) begin
          if (lk_q.rw) begin
            load = 1'b1;
          end else begin
            lk_d.sda_oe = 1'b0;
            lk_d.bits = 4'h0;
            lk_d.byte_n = 2'h0;
            lk_d.st = wam_pkg::BUS_WR;
          end
        end
      end
      wam_pkg::BUS_WR: begin
        if (rise) begin
          lk_d.shift = {lk_q.shift[6:0], lk_q.sda_s[1]};
          lk_d.bits = lk_q.bits + 4'h1;
        end
        if (fall && lk_q.bits == wam_pkg::BITS_BYTE) begin
          lk_d.sda_oe = 1'b1;
          lk_d.st = wam_pkg::BUS_WR_ACK;
          if (lk_q.byte_n == 2'h0) begin
            lk_d.ptr = lk_q.shift[2:0];
            lk_d.rd_lo = 1'b0;
            lk_d.byte_n = 2'h1;
          end else if (lk_q.byte_n == 2'h1 && !two) begin
            if (lk_q.ptr == wam_pkg::PTR_CONFIG) begin
              lk_d.cfg = lk_q.shift;
            end else begin
              if (lk_q.shift[wam_pkg::STS_OVER]) begin
                lk_d.over = 1'b0;
              end
              if (lk_q.shift[wam_pkg::STS_UNDER]) begin
                lk_d.under = 1'b0;
              end
            end
          end else if (lk_q.byte_n == 2'h1) begin
            lk_d.wr_hi = lk_q.shift;
            lk_d.byte_n = 2'h2;
          end else begin
            lk_d.byte_n = 2'h1;
            unique case (lk_q.ptr)
              wam_pkg::PTR_LOW: lk_d.low = wv;
              wam_pkg::PTR_HIGH: lk_d.high = wv;
              wam_pkg::PTR_HYST: lk_d.hyst = wv;
              wam_pkg::PTR_MIN: lk_d.minv = wv;
              wam_pkg::PTR_MAX: lk_d.maxv = wv;
              default: begin
              end
            endcase
          end
        end
      end
      wam_pkg::BUS_WR_ACK: begin
        if (fall) begin
          lk_d.sda_oe = 1'b0;
          lk_d.bits = 4'h0;
          lk_d.st = wam_pkg::BUS_WR;
        end
      end
      wam_pkg::BUS_RD: begin
        if (fall) begin
          if (lk_q.bits == wam_pkg::BITS_LAST) begin
            lk_d.sda_oe = 1'b0;
            lk_d.st = wam_pkg::BUS_RD_ACK;
          end else begin
            lk_d.bits = lk_q.bits + 4'h1;
            lk_d.tx = {lk_q.tx[6:0], 1'b0};
            lk_d.sda_oe = ~lk_q.tx[6];
          end
        end
      end
      wam_pkg::BUS_RD_ACK: begin
        if (rise) begin
          lk_d.mack = ~lk_q.sda_s[1];
        end
        if (fall) begin
          if (lk_q.mack) begin
            load = 1'b1;
          end else begin
            lk_d.st = wam_pkg::BUS_IDLE;
          end
        end
      end
    endcase
    // next read byte onto the line
    if (load) begin
      lk_d.tx = nb;
      lk_d.sda_oe = ~nb[7];
      lk_d.bits = 4'h0;
      lk_d.st = wam_pkg::BUS_RD;
      if (two) begin
        lk_d.rd_lo = ~lk_q.rd_lo;
      end
    end
    // start and repeated start keep the speed mode
    if (start_c) begin
      lk_d.st = wam_pkg::BUS_ADDR;
      lk_d.bits = 4'h0;
      lk_d.shift = 8'h00;
      lk_d.sda_oe = 1'b0;
      lk_d.rd_lo = 1'b0;
    end
    if (stop_c) begin
      lk_d.st = wam_pkg::BUS_IDLE;
      lk_d.hs = 1'b0;
      lk_d.sda_oe = 1'b0;
    end
    // window compare once per finished conversion
    if (evt) begin
      lk_d.res = smp;
      if (!lk_q.cfg[wam_pkg::CFG_HOLD] &&
          ({1'b0, smp} + {1'b0, lk_q.hyst} < {1'b0, lk_q.high})) begin
        lk_d.over = 1'b0;
      end
      if (!lk_q.cfg[wam_pkg::CFG_HOLD] &&
          ({1'b0, smp} > {1'b0, lk_q.low} + {1'b0, lk_q.hyst})) begin
        lk_d.under = 1'b0;
      end
      // set wins over a same-cycle clear
      if (smp > lk_q.high) begin
        lk_d.over = 1'b1;
      end
      if (smp < lk_q.low) begin
        lk_d.under = 1'b1;
      end
      if (auto_on && smp < lk_d.minv) begin
        lk_d.minv = smp;
      end
      if (auto_on && smp > lk_d.maxv) begin
        lk_d.maxv = smp;
      end
    end
    // alert pin level with polarity
    lk_d.alert = (lk_q.cfg[wam_pkg::CFG_PIN_EN] && (lk_q.over || lk_q.under))
                 ? lk_q.cfg[wam_pkg::CFG_POL] : ~lk_q.cfg[wam_pkg::CFG_POL];
    if (!lrst_n) begin
      lk_d = wam_pkg::LINK_RST;
    end
    // synchronisers run through reset
    lk_d.rst_s = {lk_q.rst_s[0], rstn_in};
    lk_d.scl_s = {lk_q.scl_s[1:0], scl_in};
    lk_d.sda_s = {lk_q.sda_s[1:0], sda_in};
    lk_d.tog_s = {lk_q.tog_s[1:0], rf_q.tog};
    lk_d.pin_s1 = {addr_select_high_pin_in, addr_select_low_pin_in};
    lk_d.pin_s2 = lk_q.pin_s1;
  end

  always_ff @(posedge link_clk_in) begin
    lk_q <= lk_d;
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = lk_q.sda_oe;
  assign alert_out = lk_q.alert;
  assign hs_mode_out = lk_q.hs;

  // ----------------------------------------
  // checks
  // ----------------------------------------

  a_start_osc_on: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    conv_start_out |-> osc_en_out)
    else $error("conversion start without oscillator");

  a_hs_code_nack: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (lk_q.st == wam_pkg::BUS_ADDR && fall && lk_q.bits == wam_pkg::BITS_BYTE &&
     lk_q.shift[7:3] == wam_pkg::HS_CODE) |=> (!sda_oe_out && hs_mode_out) [*2])
    else $error("master code acknowledged or not noted");

  a_addr_match_ack: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (lk_q.st == wam_pkg::BUS_ADDR && fall && lk_q.bits == wam_pkg::BITS_BYTE &&
     lk_q.shift[7:1] == my_addr) |=> sda_oe_out && lk_q.st == wam_pkg::BUS_ADDR_ACK)
    else $error("own address not acknowledged");

  a_stop_hs_off: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    stop_c |=> !hs_mode_out && lk_q.st == wam_pkg::BUS_IDLE)
    else $error("high speed survives stop");

  a_rstart_keep_hs: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (start_c && hs_mode_out) |=> hs_mode_out && lk_q.st == wam_pkg::BUS_ADDR)
    else $error("repeated start lost high speed");

  a_over_set: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (evt && smp > lk_q.high) |=> lk_q.over && lk_q.res == $past(smp))
    else $error("over flag not set");

  a_under_set: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (evt && smp < lk_q.low) |=> lk_q.under)
    else $error("under flag not set");

  a_no_evt_quiet: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (!evt && !lk_q.over && lk_q.st != wam_pkg::BUS_WR) |=> !lk_q.over)
    else $error("flag raised between conversions");

  a_hold_keeps: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (lk_q.cfg[wam_pkg::CFG_HOLD] && lk_q.over && lk_q.st != wam_pkg::BUS_WR) |=> lk_q.over)
    else $error("held alert cleared itself");

  a_hyst_clear: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (evt && !lk_q.cfg[wam_pkg::CFG_HOLD] &&
     ({1'b0, smp} + {1'b0, lk_q.hyst} < {1'b0, lk_q.high})) |=> !lk_q.over)
    else $error("over not cleared below hysteresis");

  a_alert_active: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (lk_q.cfg[wam_pkg::CFG_PIN_EN] && lk_q.over && lk_q.st != wam_pkg::BUS_WR)
    |=> alert_out == lk_q.cfg[wam_pkg::CFG_POL])
    else $error("alert pin not active");

  a_alert_idle_pol: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    !lk_q.cfg[wam_pkg::CFG_PIN_EN] |=> alert_out == !$past(lk_q.cfg[wam_pkg::CFG_POL]))
    else $error("alert idle level wrong");

  a_ptr_load: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (lk_q.st == wam_pkg::BUS_WR && fall && lk_q.bits == wam_pkg::BITS_BYTE &&
     lk_q.byte_n == 2'h0) |=> lk_q.ptr == $past(lk_q.shift[2:0]))
    else $error("pointer not loaded");

  a_max_track: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
    (evt && auto_on && smp > lk_q.maxv && lk_q.st != wam_pkg::BUS_WR)
    |=> lk_q.maxv == $past(smp))
    else $error("highest result not tracked");

endmodule

// ===== dv/i2c_master_model.sv
`timescale 1ns/1ps
// bit-banged bus master; a line value of 1 means released to the pull-up
module i2c_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  logic quiet = 1'b0;

  // idle bus, both lines released
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // ----------------------------------------
  // line phases, eight link cycles each
  // ----------------------------------------
  task automatic drv(input logic c, input logic d);
    scl_out <= c;
    sda_out <= d;
    repeat (8) @(posedge clk_in);
  endtask

  // start or repeated start, leaves the clock low
  task automatic start();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask

  task automatic stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask

  // one clock pulse; lng holds the clock high past a microsecond
  task automatic bit_x(input logic b, input logic lng, output logic r);
    drv(1'b0, b);
    drv(1'b1, b);
    if (lng) repeat (170) @(posedge clk_in);
    r = sda_in;
    drv(1'b0, b);
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], 1'b0, r);
    bit_x(1'b1, quiet, r);
    ack = !r;
  endtask

  // master acks each byte it wants more after, nacks the last
  task automatic rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, 1'b0, r);
      d[i] = r;
    end
    bit_x(!more, quiet, r);
  endtask
endmodule

// ===== dv/i2c_window_alert_monitor_tb.sv
`timescale 1ns/1ps
module i2c_window_alert_monitor_tb;
  localparam logic [6:0] A_ZERO = 7'h50; // both select pins floating
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] hi_pin = 2'h0;
  logic [1:0] lo_pin = 2'h0;
  logic conv_done = 1'b0;
  logic [11:0] conv_res = 12'h000;
  logic [11:0] last_res = 12'h000;
  logic [11:0] auto_seq [3] = '{12'h300, 12'h900, 12'h200};
  logic auto_on = 1'b0;
  logic man_go = 1'b0;
  logic [11:0] man_val = 12'h000;
  int oe2_n = 0;
  logic scl, m_sda, sda_w, sda1, oe1, sda2, oe2, conv_start, osc_en, alert, hs;
  int idx = 0;
  int n_fail = 0;
  int samples_checked = 0;

  // ----------------------------------------
  // clocks, bus wire, devices
  // ----------------------------------------
  always #50 ref_clk = ~ref_clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  assign sda_w = m_sda & (oe1 ? sda1 : 1'b1) & (oe2 ? sda2 : 1'b1);

  i2c_window_alert_monitor #(.HAS_ADDR_PINS(1'b1), .AUTO_BASE_CYCLES(4)) dut (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .link_clk_in(link_clk), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda1), .sda_oe_out(oe1), .addr_select_high_pin_in(hi_pin),
    .addr_select_low_pin_in(lo_pin), .conv_start_out(conv_start), .conv_done_in(conv_done),
    .conv_result_in(conv_res), .osc_en_out(osc_en), .alert_out(alert), .hs_mode_out(hs));
  i2c_window_alert_monitor #(.HAS_ADDR_PINS(1'b0), .AUTO_BASE_CYCLES(4)) dut_fixed (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .link_clk_in(link_clk), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda2), .sda_oe_out(oe2), .addr_select_high_pin_in(hi_pin),
    .addr_select_low_pin_in(lo_pin), .conv_start_out(), .conv_done_in(conv_done),
    .conv_result_in(conv_res), .osc_en_out(), .alert_out(), .hs_mode_out());
  i2c_master_model m (.clk_in(link_clk), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));

  // fixed-address device seen driving the wire
  always @(posedge link_clk) if (oe2) oe2_n <= oe2_n + 1;

  // converter core: one done pulse per manual request or auto start pulse
  always @(posedge ref_clk) begin
    conv_done <= man_go || (auto_on && conv_start);
    if (man_go) begin
      conv_res <= man_val;
    end else if (auto_on && conv_start) begin
      conv_res <= auto_seq[idx];
      last_res <= auto_seq[idx];
      idx <= (idx + 1) % 3;
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic addr(input logic [6:0] a, input logic rw, output logic ack);
    m.start();
    m.wr({a, rw}, ack);
  endtask

  task automatic probe(input logic [6:0] a, output logic ack);
    addr(a, 1'b0, ack);
    m.stop();
  endtask

  task automatic wreg(input logic [2:0] p, input logic [15:0] d, input logic two);
    logic ack;
    addr(A_ZERO, 1'b0, ack);
    m.wr({5'h00, p}, ack);
    if (two) m.wr(d[15:8], ack);
    m.wr(d[7:0], ack);
    m.stop();
  endtask

  task automatic rd(input logic setp, input logic [2:0] p, input logic two,
                    output logic [15:0] v);
    logic ack;
    v = 16'h0000;
    if (setp) begin
      addr(A_ZERO, 1'b0, ack);
      m.wr({5'h00, p}, ack);
    end
    addr(A_ZERO, 1'b1, ack);
    if (two) m.rd(1'b1, v[15:8]);
    m.rd(1'b0, v[7:0]);
    m.stop();
  endtask

  task automatic conv(input logic [11:0] r);
    @(posedge ref_clk);
    man_go <= 1'b1;
    man_val <= r;
    @(posedge ref_clk);
    man_go <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic st(input logic [1:0] f, input logic al);
    logic [15:0] v;
    rd(1'b1, wam_pkg::PTR_STATUS, 1'b0, v);
    chk("status", v, {14'h0000, f});
    chk("alert pin", 16'(alert), 16'(al));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] v;
    logic [15:0] exp [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0FFF, 16'h0000, 16'h0FFF, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      rd(1'b1, 3'(i), (i != 1 && i != 2), v);
      chk("reset value", v, exp[i]);
    end
  endtask

  task automatic t_addr();
    logic ack;
    int base;
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        @(posedge ref_clk);
        hi_pin <= 2'(h);
        lo_pin <= 2'(l);
        repeat (4) @(posedge ref_clk);
        probe({3'h5, 2'(h), 2'(l)}, ack);
        chk("address ack", 16'(ack), 16'h0001);
      end
    end
    // back to all floating, so only the fixed variant sits at its address
    @(posedge ref_clk);
    hi_pin <= 2'h0;
    lo_pin <= 2'h0;
    repeat (4) @(posedge ref_clk);
    probe(7'h3A, ack);
    chk("foreign address", 16'(ack), 16'h0000);
    base = oe2_n;
    probe(A_ZERO, ack);
    chk("floating address ack", 16'(ack), 16'h0001);
    chk("fixed variant silent", 16'(oe2_n - base), 16'h0000);
    probe(7'h54, ack);
    chk("fixed variant ack", 16'(ack), 16'h0001);
  endtask

  task automatic t_hs();
    logic ack;
    m.start();
    m.wr(8'h0B, ack);
    chk("code nack", 16'(ack), 16'h0000);
    chk("hs entered", 16'(hs), 16'h0001);
    addr(A_ZERO, 1'b0, ack);
    chk("hs address ack", 16'(ack), 16'h0001);
    addr(A_ZERO, 1'b0, ack);
    chk("hs kept", 16'(hs), 16'h0001);
    m.stop();
    chk("hs left", 16'(hs), 16'h0000);
    probe(A_ZERO, ack);
    chk("plain after stop", 16'(hs), 16'h0000);
  endtask

  task automatic t_regs();
    logic [15:0] v;
    wreg(wam_pkg::PTR_HYST, 16'h0123, 1'b1);
    wreg(wam_pkg::PTR_HIGH, 16'h0ABC, 1'b1);
    rd(1'b1, wam_pkg::PTR_HYST, 1'b1, v);
    chk("hysteresis", v, 16'h0123);
    rd(1'b1, wam_pkg::PTR_HIGH, 1'b1, v);
    chk("upper limit", v, 16'h0ABC);
    m.quiet = 1'b1;
    rd(1'b0, 3'h0, 1'b1, v);
    m.quiet = 1'b0;
    chk("preset pointer", v, 16'h0ABC);
  endtask

  task automatic t_alert();
    logic [15:0] v;
    wreg(wam_pkg::PTR_LOW, 16'h0100, 1'b1);
    wreg(wam_pkg::PTR_HIGH, 16'h0800, 1'b1);
    wreg(wam_pkg::PTR_HYST, 16'h0040, 1'b1);
    wreg(wam_pkg::PTR_CONFIG, 16'h000C, 1'b0);
    conv(12'h800);
    st(2'h0, 1'b1);
    conv(12'h900);
    st(2'h2, 1'b0);
    rd(1'b1, wam_pkg::PTR_RESULT, 1'b1, v);
    chk("result flag bit", v, 16'h8900);
    conv(12'h7D0);
    st(2'h2, 1'b0);
    conv(12'h7B0);
    st(2'h0, 1'b1);
    conv(12'h0F0);
    st(2'h1, 1'b0);
    conv(12'h140);
    st(2'h1, 1'b0);
    conv(12'h150);
    st(2'h0, 1'b1);
    conv(12'h900);
    wreg(wam_pkg::PTR_STATUS, 16'h0002, 1'b0);
    st(2'h0, 1'b1);
    conv(12'h900);
    st(2'h2, 1'b0);
    conv(12'h500);
    wreg(wam_pkg::PTR_CONFIG, 16'h001D, 1'b0);
    conv(12'h0F0);
    st(2'h1, 1'b1);
    conv(12'h500);
    st(2'h1, 1'b1);
    wreg(wam_pkg::PTR_STATUS, 16'h0001, 1'b0);
    st(2'h0, 1'b0);
    wreg(wam_pkg::PTR_CONFIG, 16'h0010, 1'b0);
    conv(12'h900);
    st(2'h2, 1'b1);
    rd(1'b1, wam_pkg::PTR_RESULT, 1'b1, v);
    chk("result no flag", v, 16'h0900);
    wreg(wam_pkg::PTR_STATUS, 16'h0002, 1'b0);
  endtask

  task automatic t_auto();
    logic [15:0] v;
    int n;
    wreg(wam_pkg::PTR_HIGH, 16'h0FFF, 1'b1);
    @(posedge ref_clk);
    auto_on <= 1'b1;
    for (int c = 1; c < 4; c += 2) begin
      wreg(wam_pkg::PTR_CONFIG, {8'h00, 3'(c), 5'h00}, 1'b0);
      repeat (40) @(negedge ref_clk);
      chk("oscillator on", 16'(osc_en), 16'h0001);
      do @(negedge ref_clk); while (conv_start !== 1'b1);
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while (conv_start !== 1'b1 && n < 100);
      chk("auto period", 16'(n), 16'(4 << (c - 1)));
    end
    wreg(wam_pkg::PTR_CONFIG, 16'h0000, 1'b0);
    repeat (10) @(posedge ref_clk);
    auto_on <= 1'b0;
    chk("oscillator off", 16'(osc_en), 16'h0000);
    rd(1'b1, wam_pkg::PTR_RESULT, 1'b1, v);
    chk("auto result", v, {4'h0, last_res});
    rd(1'b1, wam_pkg::PTR_MIN, 1'b1, v);
    chk("lowest", v, 16'h0200);
    rd(1'b1, wam_pkg::PTR_MAX, 1'b1, v);
    chk("highest", v, 16'h0900);
    wreg(wam_pkg::PTR_MIN, 16'h0FFF, 1'b1);
    rd(1'b1, wam_pkg::PTR_MIN, 1'b1, v);
    chk("lowest reset", v, 16'h0FFF);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_addr();
    t_hs();
    t_regs();
    t_alert();
    t_auto();
    end_sim();
  end

  initial begin
    #3000000;
    n_fail++;
    end_sim();
  end
endmodule
